// file: logic/timer2_comparator_pkg.sv
package timer2_comparator_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_TIMER2_SCALING_CFG = 6'h17;
  localparam logic [5:0] IDX_COMPARATOR_CONTROL = 6'h18;
  localparam logic [5:0] IDX_COMPARATOR_REFERENCE_SELECT = 6'h19;
  localparam logic [5:0] IDX_TIMER2_CONTROL = 6'h1C;
  localparam logic [5:0] IDX_TIMER2_COUNT_VALUE = 6'h1D;
  localparam logic [5:0] IDX_TIMER2_BOUND_VALUE = 6'h09;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_PRESCALE = 6'h00;
  localparam logic [4:0] RST_SCALAR = 5'h00;

  // Comparator control field positions
  localparam int CC_ENABLE = 7;
  localparam int CC_RESULT = 6;
  localparam int CC_SAMPLE = 5;
  localparam int CC_INVERT = 4;
  localparam int CC_MINUS_HI = 3;
  localparam int CC_MINUS_LO = 1;
  localparam int CC_PLUS = 0;

  // Reference select field positions
  localparam int RS_OUT_EN = 7;
  localparam int RS_WAKE_EN = 6;
  localparam int RS_HIGH_RANGE = 5;
  localparam int RS_LOW_RANGE = 4;
  localparam int RS_LEVEL_HI = 3;

  // Timer control field positions
  localparam int TC_CLK_HI = 7;
  localparam int TC_CLK_LO = 4;
  localparam int TC_OUT_HI = 3;
  localparam int TC_OUT_LO = 2;
  localparam int TC_MODE = 1;
  localparam int TC_INVERT = 0;

  // Scaling register field positions
  localparam int SC_RES = 7;
  localparam int SC_PRE_HI = 6;
  localparam int SC_PRE_LO = 5;
  localparam int SC_SCALAR_HI = 4;

  // Timer clock source codes
  localparam logic [3:0] CLK_STOP = 4'h0;
  localparam logic [3:0] CLK_SYSTEM = 4'h1;
  localparam logic [3:0] CLK_FAST_OSC = 4'h2;
  localparam logic [3:0] CLK_EXT_OSC = 4'h3;
  localparam logic [3:0] CLK_SLOW_OSC = 4'h4;
  localparam logic [3:0] CLK_COMPARATOR = 4'h5;
  localparam logic [3:0] CLK_PA0_RISE = 4'h8;
  localparam logic [3:0] CLK_PA0_FALL = 4'h9;
  localparam logic [3:0] CLK_PB0_RISE = 4'hA;
  localparam logic [3:0] CLK_PB0_FALL = 4'hB;
  localparam logic [3:0] CLK_PA4_RISE = 4'hC;
  localparam logic [3:0] CLK_PA4_FALL = 4'hD;

  // Timer output routing codes
  localparam logic [1:0] OUT_NONE = 2'h0;
  localparam logic [1:0] OUT_PB2 = 2'h1;
  localparam logic [1:0] OUT_PA3 = 2'h2;
  localparam logic [1:0] OUT_PB4 = 2'h3;

  // Prescaler terminal counts for divide by 1, 4, 16, 64
  localparam logic [5:0] PRE_TOP_1 = 6'h00;
  localparam logic [5:0] PRE_TOP_4 = 6'h03;
  localparam logic [5:0] PRE_TOP_16 = 6'h0F;
  localparam logic [5:0] PRE_TOP_64 = 6'h3F;

  // PWM wrap values for 8, 7 and 6 bit resolution
  localparam logic [7:0] PWM_TOP_8 = 8'hFF;
  localparam logic [7:0] PWM_TOP_7 = 8'h7F;
  localparam logic [7:0] PWM_TOP_6 = 8'h3F;

  // Timer output pins, level and enable per pin
  typedef struct packed {
    logic pb4;
    logic pa3;
    logic pb2;
  } timer_pins_t;

  // Asynchronous sources that are synchronised before use
  typedef struct packed {
    logic comp;
    logic pa4;
    logic pb0;
    logic pa0;
    logic slow_osc;
    logic ext_osc;
    logic fast_osc;
  } async_src_t;

endpackage

// file: logic/timer2_comparator_ctrl.sv
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module timer2_comparator_ctrl
  import timer2_comparator_pkg::*;
#(
  parameter bit timer2_resolution_option = 1'b0
)(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous clock and pin inputs
  input wire logic fast_internal_osc,
  input wire logic external_osc,
  input wire logic slow_internal_osc,
  input wire logic port_a_pin0,
  input wire logic port_b_pin0,
  input wire logic port_a_pin4,
  // Analog comparator interface
  input wire logic comp_raw_result,
  output logic comp_enable,
  output logic [2:0] comp_minus_sel,
  output logic comp_plus_sel,
  output logic ladder_high_range,
  output logic ladder_low_range,
  output logic [3:0] ladder_level,
  output logic comp_wake,
  // Comparator output on port A pin 0
  output logic comp_pa0_out,
  output logic comp_pa0_oe,
  // Timer output pins
  output timer_pins_t timer_pin_out,
  output timer_pins_t timer_pin_oe
);

  // Register word decode on a word-aligned address
  function automatic logic reg_hit(input logic [7:0] addr, input logic [5:0] idx);
    reg_hit = (addr[7:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  // Software-visible control bytes
  logic [7:0] scaling_q;
  logic [7:0] comp_ctrl_q;
  logic [7:0] ref_sel_q;
  logic [7:0] tmr_ctrl_q;
  // Counter and bound; the counter is also written by software
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [7:0] bound_q;

  // Prescaler and scalar dividers ahead of the counter
  logic [5:0] pre_cnt_q;
  logic [5:0] pre_cnt_d;
  logic [4:0] scl_cnt_q;
  logic [4:0] scl_cnt_d;
  // Timer output level before polarity and routing
  logic tmr_out_q;
  logic tmr_out_d;

  // Comparator result and its delayed copy for edge detection
  logic comp_sampled_q;
  logic comp_result_q;

  // Registered bus answer
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // Synchroniser stages and edge history of the pin and clock inputs
  async_src_t sync1_q;
  async_src_t sync2_q;
  async_src_t prev_q;
  async_src_t src_now;
  async_src_t rise;
  async_src_t fall;

  // Decoding of the current access
  wire logic hit_scaling = reg_hit(paddr, IDX_TIMER2_SCALING_CFG);
  wire logic hit_comp_ctrl = reg_hit(paddr, IDX_COMPARATOR_CONTROL);
  wire logic hit_ref_sel = reg_hit(paddr, IDX_COMPARATOR_REFERENCE_SELECT);
  wire logic hit_tmr_ctrl = reg_hit(paddr, IDX_TIMER2_CONTROL);
  wire logic hit_count = reg_hit(paddr, IDX_TIMER2_COUNT_VALUE);
  wire logic hit_bound = reg_hit(paddr, IDX_TIMER2_BOUND_VALUE);
  wire logic hit_any = hit_scaling | hit_comp_ctrl | hit_ref_sel | hit_tmr_ctrl |
                       hit_count | hit_bound;
  // Access phase waits one cycle so that read data comes from a flop
  wire logic acc_first = psel & penable & ~pready_q;
  wire logic acc_done = psel & penable & pready_q;
  wire logic wr_ok = acc_done & pwrite & hit_any;
  wire logic [7:0] wbyte = pwdata[7:0];

  // Edge views of the synchronised sources
  assign src_now = sync2_q;
  assign rise = src_now & ~prev_q;
  assign fall = ~src_now & prev_q;

  // Timer clock source selection
  // Pin and oscillator edges arrive about two cycles late through the synchroniser
  wire logic [3:0] clk_sel = tmr_ctrl_q[TC_CLK_HI:TC_CLK_LO];
  logic timer2_tick;
  always_comb
  begin
    unique case (clk_sel)
      CLK_SYSTEM: timer2_tick = 1'b1;
      CLK_FAST_OSC: timer2_tick = rise.fast_osc;
      CLK_EXT_OSC: timer2_tick = rise.ext_osc;
      CLK_SLOW_OSC: timer2_tick = rise.slow_osc;
      CLK_COMPARATOR: timer2_tick = comp_result_q & ~comp_sampled_q;
      CLK_PA0_RISE: timer2_tick = rise.pa0;
      CLK_PA0_FALL: timer2_tick = fall.pa0;
      CLK_PB0_RISE: timer2_tick = rise.pb0;
      CLK_PB0_FALL: timer2_tick = fall.pb0;
      CLK_PA4_RISE: timer2_tick = rise.pa4;
      CLK_PA4_FALL: timer2_tick = fall.pa4;
      default: timer2_tick = 1'b0; // Stop and reserved codes hold the count
    endcase
  end

  // Prescaler terminal count
  logic [5:0] pre_top;
  always_comb
  begin
    unique case (scaling_q[SC_PRE_HI:SC_PRE_LO])
      2'h0: pre_top = PRE_TOP_1;
      2'h1: pre_top = PRE_TOP_4;
      2'h2: pre_top = PRE_TOP_16;
      2'h3: pre_top = PRE_TOP_64;
    endcase
  end

  // Prescaler and scalar chain; the scalar divides by its value plus one
  // Greater-or-equal compares let a smaller divide take effect without a long wrap
  wire logic pre_wrap = timer2_tick & (pre_cnt_q >= pre_top);
  wire logic [4:0] scalar = scaling_q[SC_SCALAR_HI:0];
  wire logic cnt_tick = pre_wrap & (scl_cnt_q >= scalar);
  assign pre_cnt_d = ~timer2_tick ? pre_cnt_q : (pre_wrap ? 6'h00 : pre_cnt_q + 6'h01);
  assign scl_cnt_d = ~pre_wrap ? scl_cnt_q :
                     ((scl_cnt_q >= scalar) ? 5'h00 : scl_cnt_q + 5'h01);

  // Resolution; the reduced width is fixed when the part is built
  wire logic [7:0] pwm_top = ~scaling_q[SC_RES] ? PWM_TOP_8 :
                             (timer2_resolution_option ? PWM_TOP_7 : PWM_TOP_6);
  wire logic pwm_mode = tmr_ctrl_q[TC_MODE];
  wire logic [7:0] wrap_val = pwm_mode ? pwm_top : bound_q;

  // Counter next value; a software write wins over a tick
  wire logic count_wr = wr_ok & hit_count;
  always_comb
  begin
    count_d = count_q;
    if (count_wr)
    begin
      count_d = wbyte;
    end
    else if (cnt_tick)
    begin
      count_d = (count_q >= wrap_val) ? 8'h00 : count_q + 8'h01;
    end
  end

  // Period mode toggles on reaching the bound, PWM is high below it
  // A bound write shows in PWM at once; period mode waits for the next match
  always_comb
  begin
    tmr_out_d = tmr_out_q;
    if (pwm_mode)
    begin
      tmr_out_d = (count_q < bound_q);
    end
    else if (cnt_tick && (count_q == bound_q))
    begin
      tmr_out_d = ~tmr_out_q;
    end
  end

  // Comparator result path: polarity, optional sampling, gated by enable
  wire logic comp_on = comp_ctrl_q[CC_ENABLE];
  wire logic comp_polar = src_now.comp ^ comp_ctrl_q[CC_INVERT];
  wire logic comp_result_d = ~comp_on ? 1'b0 :
                             (~comp_ctrl_q[CC_SAMPLE] ? comp_polar :
                              (timer2_tick ? comp_polar : comp_result_q));
  wire logic wake_d = ref_sel_q[RS_WAKE_EN] & (comp_result_d ^ comp_result_q);

  // Timer pin routing after polarity
  wire logic tmr_level = tmr_out_q ^ tmr_ctrl_q[TC_INVERT];
  wire logic [1:0] out_sel = tmr_ctrl_q[TC_OUT_HI:TC_OUT_LO];
  timer_pins_t pin_oe_d;
  assign pin_oe_d.pb2 = (out_sel == OUT_PB2);
  assign pin_oe_d.pa3 = (out_sel == OUT_PA3);
  assign pin_oe_d.pb4 = (out_sel == OUT_PB4);

  // Read data; write-only registers read as zero
  logic [7:0] rbyte;
  always_comb
  begin
    rbyte = 8'h00;
    if (hit_comp_ctrl)
    begin
      rbyte = comp_ctrl_q;
      rbyte[CC_RESULT] = comp_result_q;
    end
    else if (hit_tmr_ctrl)
    begin
      rbyte = tmr_ctrl_q;
    end
    else if (hit_count)
    begin
      rbyte = count_q;
    end
  end

  // Two-flop synchronisers, then an edge-history flop on the second stage
  // Nothing but the second stage reads the first, so metastability stays contained
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q <= '0;
    end
    else
    begin
      sync1_q <= {comp_raw_result, port_a_pin4, port_b_pin0, port_a_pin0,
                  slow_internal_osc, external_osc, fast_internal_osc};
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // APB answer
  // Read data is captured in the first access cycle so it stands with pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else
    begin
      pready_q <= acc_first;
      pslverr_q <= acc_first & ~hit_any; // Unmapped words answer with an error
      if (acc_first)
      begin
        prdata_q <= {24'h00_0000, rbyte};
      end
    end
  end

  // Software registers; the result bit of control is not stored
  // Reserved minus-input codes are kept as written; the analog side ignores them
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      scaling_q <= RST_BYTE;
      comp_ctrl_q <= RST_BYTE;
      ref_sel_q <= RST_BYTE;
      tmr_ctrl_q <= RST_BYTE;
      bound_q <= RST_BYTE;
    end
    else
    begin
      if (wr_ok & hit_scaling)
      begin
        scaling_q <= wbyte;
      end
      if (wr_ok & hit_comp_ctrl)
      begin
        comp_ctrl_q <= {wbyte[7], 1'b0, wbyte[5:0]};
      end
      if (wr_ok & hit_ref_sel)
      begin
        ref_sel_q <= wbyte;
      end
      if (wr_ok & hit_tmr_ctrl)
      begin
        tmr_ctrl_q <= wbyte;
      end
      if (wr_ok & hit_bound)
      begin
        bound_q <= wbyte;
      end
    end
  end

  // Timer datapath
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_cnt_q <= RST_PRESCALE;
      scl_cnt_q <= RST_SCALAR;
      count_q <= RST_BYTE;
      tmr_out_q <= 1'b0;
    end
    else
    begin
      pre_cnt_q <= pre_cnt_d;
      scl_cnt_q <= scl_cnt_d;
      count_q <= count_d;
      tmr_out_q <= tmr_out_d;
    end
  end

  // Comparator state and registered pin outputs
  // Selects are registered so the analog side never sees decode glitches
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      comp_result_q <= 1'b0;
      comp_sampled_q <= 1'b0;
      comp_wake <= 1'b0;
      comp_enable <= 1'b0;
      comp_minus_sel <= 3'h0;
      comp_plus_sel <= 1'b0;
      ladder_high_range <= 1'b0;
      ladder_low_range <= 1'b0;
      ladder_level <= 4'h0;
      comp_pa0_out <= 1'b0;
      comp_pa0_oe <= 1'b0;
      timer_pin_out <= '0;
      timer_pin_oe <= '0;
    end
    else
    begin
      comp_result_q <= comp_result_d;
      comp_sampled_q <= comp_result_q;
      comp_wake <= wake_d;
      comp_enable <= comp_on;
      comp_minus_sel <= comp_ctrl_q[CC_MINUS_HI:CC_MINUS_LO];
      comp_plus_sel <= comp_ctrl_q[CC_PLUS];
      ladder_high_range <= ref_sel_q[RS_HIGH_RANGE];
      ladder_low_range <= ref_sel_q[RS_LOW_RANGE];
      ladder_level <= ref_sel_q[RS_LEVEL_HI:0];
      comp_pa0_out <= ref_sel_q[RS_OUT_EN] & comp_result_q;
      comp_pa0_oe <= ref_sel_q[RS_OUT_EN];
      timer_pin_out <= {3{tmr_level}} & pin_oe_d;
      timer_pin_oe <= pin_oe_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

endmodule

`default_nettype wire

// file: bench/timer2_comparator_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
module timer2_comparator_ctrl_props
  import timer2_comparator_pkg::*;
(
  // Clock, reset and register bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Comparator and timer outputs
  input wire logic comp_enable, comp_plus_sel, comp_wake,
  input wire logic [2:0] comp_minus_sel,
  input wire logic ladder_high_range, ladder_low_range,
  input wire logic [3:0] ladder_level,
  input wire logic comp_pa0_out, comp_pa0_oe,
  input wire timer_pins_t timer_pin_oe
);
  logic [7:0] cc_q, rs_q, tc_q;
  // Decode of completing writes and of the register map
  wire wr_w = psel && penable && pready && pwrite;
  wire map_w = paddr inside {8'h5C, 8'h60, 8'h64, 8'h70, 8'h74, 8'h24};
  wire wo_w = paddr inside {8'h5C, 8'h64, 8'h24};
  wire [2:0] oe_exp = (tc_q[3:2] == 2'h0) ? 3'h0 : 3'h1 << (tc_q[3:2] - 2'h1);

  // Shadow copies; outputs are compared only once a shadow has settled
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      cc_q <= 8'h00;
      rs_q <= 8'h00;
      tc_q <= 8'h00;
    end
    else if (wr_w)
    begin
      if (paddr == 8'h60) cc_q <= pwdata[7:0];
      if (paddr == 8'h64) rs_q <= pwdata[7:0];
      if (paddr == 8'h70) tc_q <= pwdata[7:0];
    end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_one_wait_state: assert property (psel && penable && !pready |=> pready)
    else $error("pready not one cycle after access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unmapped_error: assert property (pready |-> pslverr == !map_w)
    else $error("pslverr does not match address map");
  a_wo_reads_zero: assert property (pready && !pwrite && wo_w |-> prdata == 32'h0)
    else $error("write-only register read not zero");
  a_comp_fields: assert property ($past(cc_q, 2) == cc_q |->
    {comp_enable, comp_minus_sel, comp_plus_sel} == {cc_q[7], cc_q[3:0]})
    else $error("comparator control outputs mismatch");
  a_ref_fields: assert property ($past(rs_q, 2) == rs_q |->
    {comp_pa0_oe, ladder_high_range, ladder_low_range, ladder_level} == {rs_q[7], rs_q[5:0]})
    else $error("reference select outputs mismatch");
  a_pa0_gated: assert property (!comp_pa0_oe |-> !comp_pa0_out)
    else $error("comparator drives pin while disabled");
  a_wake_enabled: assert property (comp_wake |-> rs_q[6] || $past(rs_q[6]))
    else $error("wake pulse while wake disabled");
  a_timer_route: assert property ($past(tc_q, 2) == tc_q |-> timer_pin_oe == oe_exp)
    else $error("timer output routing mismatch");

  c_error: cover property (pready && pslverr);
  c_wake: cover property (comp_wake);
  c_route: cover property ($rose(timer_pin_oe[0]));
endmodule

bind timer2_comparator_ctrl timer2_comparator_ctrl_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .comp_enable(comp_enable), .comp_plus_sel(comp_plus_sel), .comp_wake(comp_wake),
  .comp_minus_sel(comp_minus_sel), .ladder_high_range(ladder_high_range),
  .ladder_low_range(ladder_low_range), .ladder_level(ladder_level),
  .comp_pa0_out(comp_pa0_out), .comp_pa0_oe(comp_pa0_oe), .timer_pin_oe(timer_pin_oe)
);
`default_nettype wire

// file: bench/timer2_comparator_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module timer2_comparator_ctrl_tb_top;
  import timer2_comparator_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] src; // fast, ext, slow, pa0, pb0, pa4, comparator raw
  logic comp_enable, comp_plus_sel, comp_wake, comp_pa0_out, comp_pa0_oe;
  logic ladder_high_range, ladder_low_range;
  logic [2:0] comp_minus_sel;
  logic [3:0] ladder_level;
  timer_pins_t timer_pin_out, timer_pin_oe;
  int bad_count, total_checks, wakes;

  timer2_comparator_ctrl #(.timer2_resolution_option(1'b0)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_internal_osc(src[0]), .external_osc(src[1]), .slow_internal_osc(src[2]),
    .port_a_pin0(src[3]), .port_b_pin0(src[4]), .port_a_pin4(src[5]),
    .comp_raw_result(src[6]), .comp_enable(comp_enable), .comp_minus_sel(comp_minus_sel),
    .comp_plus_sel(comp_plus_sel), .ladder_high_range(ladder_high_range),
    .ladder_low_range(ladder_low_range), .ladder_level(ladder_level), .comp_wake(comp_wake),
    .comp_pa0_out(comp_pa0_out), .comp_pa0_oe(comp_pa0_oe),
    .timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe)
  );

  // Free-running 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Wake pulses are counted here so no single pulse is missed
  always @(posedge pclk)
    if (comp_wake === 1'b1) wakes++;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; pready is polled since the master assumes no fixed latency
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Half period of the pb2 output in pclk cycles, after one toggle to align
  task automatic span(output int n);
    logic v;
    for (int k = 0; k < 2; k++)
    begin
      @(posedge pclk);
      v = timer_pin_out.pb2;
      n = 1;
      while (timer_pin_out.pb2 === v && n < 600)
      begin
        @(posedge pclk);
        n++;
      end
    end
  endtask

  task automatic hi_cnt(input int n, output int h);
    h = 0;
    repeat (n)
    begin
      @(posedge pclk);
      if (timer_pin_out.pb2 === 1'b1) h++;
    end
  endtask

  task automatic t_bus;
    apb(0, 8'h60, 8'h00);
    chk(rd, 32'h0);
    apb(0, 8'h70, 8'h00);
    chk(rd, 32'h0);
    apb(0, 8'h08, 8'h00);
    chk({31'h0, err}, 32'h1);
    apb(1, 8'h61, 8'hFF);
    chk({31'h0, err}, 32'h1);
    apb(1, 8'h74, 8'hA5);
    apb(0, 8'h74, 8'h00);
    chk(rd, 32'hA5);
    $display("bus test done");
  endtask

  task automatic t_comp;
    apb(1, 8'h60, 8'hD0);
    waitc(6);
    apb(0, 8'h60, 8'h00);
    chk(rd, 32'hD0);
    src[6] <= 1'b1;
    waitc(6);
    apb(0, 8'h60, 8'h00);
    chk(rd, 32'h90);
    apb(1, 8'h60, 8'h00);
    waitc(6);
    apb(0, 8'h60, 8'h00);
    chk(rd, 32'h0);
    apb(1, 8'h60, 8'h80);
    waitc(6);
    apb(1, 8'h60, 8'hA0);
    src[6] <= 1'b0;
    waitc(8);
    apb(0, 8'h60, 8'h00);
    chk(rd, 32'hE0);
    apb(1, 8'h60, 8'h80);
    waitc(6);
    apb(0, 8'h60, 8'h00);
    chk(rd, 32'h80);
    for (int i = 0; i < 6; i++)
    begin
      apb(1, 8'h60, {4'h0, i[2:0], 1'b1});
      waitc(3);
      chk({28'h0, comp_minus_sel, comp_plus_sel}, 32'(i * 2 + 1));
    end
    $display("comparator test done");
  endtask

  task automatic t_ref;
    int w0;
    apb(1, 8'h60, 8'h80);
    src[6] <= 1'b1;
    apb(1, 8'h64, 8'hBA);
    waitc(8);
    chk({comp_pa0_oe, comp_pa0_out, ladder_high_range, ladder_low_range, ladder_level},
      32'hFA);
    apb(0, 8'h64, 8'h00);
    chk(rd, 32'h0);
    apb(1, 8'h64, 8'h40);
    w0 = wakes;
    repeat (3)
    begin
      src[6] <= ~src[6];
      waitc(8);
    end
    chk(32'(wakes - w0), 32'h3);
    apb(1, 8'h64, 8'h00);
    src[6] <= 1'b1;
    waitc(8);
    chk(32'(wakes - w0), 32'h3);
    $display("reference test done");
  endtask

  task automatic t_timer;
    int n;
    logic v;
    logic [7:0] sc [5] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h21};
    int ex [5] = '{4, 16, 64, 256, 32};
    for (int c = 0; c < 4; c++)
    begin
      apb(1, 8'h70, {4'h0, c[1:0], 2'h0});
      waitc(3);
      chk({29'h0, timer_pin_oe}, (c == 0) ? 0 : 1 << (c - 1));
      apb(0, 8'h70, 8'h00);
      chk(rd, 32'(c * 4));
    end
    apb(1, 8'h70, 8'h04);
    waitc(3);
    v = timer_pin_out.pb2;
    apb(1, 8'h70, 8'h05);
    waitc(3);
    chk({31'h0, timer_pin_out.pb2}, {31'h0, ~v});
    apb(1, 8'h24, 8'h03);
    apb(1, 8'h70, 8'h14);
    apb(1, 8'h74, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      apb(1, 8'h5C, sc[i]);
      span(n);
      chk(32'(n), 32'(ex[i]));
    end
    apb(1, 8'h5C, 8'h00);
    apb(1, 8'h24, 8'h40);
    apb(1, 8'h70, 8'h16);
    waitc(4);
    hi_cnt(256, n);
    chk(32'(n), 32'd64);
    apb(1, 8'h24, 8'h10);
    apb(1, 8'h5C, 8'h80);
    waitc(70);
    hi_cnt(64, n);
    chk(32'(n), 32'd16);
    $display("timer test done");
  endtask

  // Each clock code except the system clock against the input that should, or should not, advance the count
  task automatic t_src;
    int tbl [16] = '{-1, -1, 0, 1, 2, 6, -1, -1, 3, 3, 4, 4, 5, 5, -1, -1};
    apb(1, 8'h5C, 8'h00);
    apb(1, 8'h24, 8'hFF);
    apb(1, 8'h60, 8'h80);
    for (int c = 0; c < 16; c++)
    begin
      if (c == 1) continue;
      apb(1, 8'h70, {c[3:0], 4'h0});
      waitc(6);
      apb(1, 8'h74, 8'h00);
      repeat (5)
      begin
        if (tbl[c] < 0) src <= 7'h7F;
        else src[tbl[c]] <= 1'b1;
        waitc(6);
        src <= 7'h00;
        waitc(6);
      end
      apb(0, 8'h74, 8'h00);
      chk(rd, (tbl[c] < 0) ? 0 : 5);
    end
    $display("clock source test done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, src} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_bus();
    t_comp();
    t_ref();
    t_timer();
    t_src();
    give_verdict();
  end

  // Watchdog against a hung handshake
  initial
  begin
    #500000;
    bad_count++;
    give_verdict();
  end
endmodule
`default_nettype wire
